/* File: pin_edge_pkg.sv */
// Constants and carrier types for the pin edge noise filter
package pin_edge_pkg;

    localparam int PIN_COUNT       = 7;
    localparam int LOW_GROUP_W     = 4;
    localparam int HIGH_GROUP_W    = 3;
    localparam int SEL_W           = 2;
    localparam int PRESCALE_W      = 6;
    localparam int CNT_W           = 10;

    localparam int CLK_PERIOD_NS   = 20;
    localparam int DIGITAL_RUN     = 4;
    localparam int ANALOG_DELAY_NS = 10000;
    localparam int SYNC_STAGES     = 2;
    // Longest lag rounds down; the synchroniser and output flop eat into it
    localparam int ANALOG_RUN      = ANALOG_DELAY_NS / CLK_PERIOD_NS - SYNC_STAGES - 1;

    localparam logic [SEL_W-1:0]        SAMPLE_SEL_RESET = 2'h0;
    localparam logic [LOW_GROUP_W-1:0]  EDGE_LOW_RESET   = 4'h0;
    localparam logic [HIGH_GROUP_W-1:0] EDGE_HIGH_RESET  = 3'h0;
    localparam logic [PRESCALE_W-1:0]   PRESCALE_RESET   = 6'h00;
    localparam logic [CNT_W-1:0]        CNT_ZERO         = 10'h000;
    localparam logic [CNT_W-1:0]        CNT_ONE          = 10'h001;

    localparam int IDX_NMI      = 0;
    localparam int IDX_TUNABLE  = 1;
    localparam int IDX_FIXED_LO = 2;
    localparam int IDX_FIXED_HI = 4;
    localparam int IDX_ANALOG_A = 5;
    localparam int IDX_ANALOG_B = 6;

    // Bit order matches the edge-select vector: nmi is bit 0
    typedef struct packed {
        logic       analog_delay_pin_b;
        logic       analog_delay_pin_a;
        logic       fixed_filter_pin_c;
        logic       fixed_filter_pin_b;
        logic       fixed_filter_pin_a;
        logic       tunable_filter_pin;
        logic       nmi_edge_pin;
    } pin_set_s;

endpackage

/* File: level_qualifier.sv */
// Synchroniser plus run-length level qualifier for one input pin
`timescale 1ns/1ps
module level_qualifier
    import pin_edge_pkg::*;
#(
    parameter int         RUN       = DIGITAL_RUN,
    parameter logic       FREE_TICK = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pin,
    input  wire logic tick,
    input  wire logic hold,
    output logic      level
);

    localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(RUN - 1);

    logic             sync_a;
    logic             sync_q;
    logic [CNT_W-1:0] run_cnt;

    wire logic differs = (sync_q != level);
    wire logic accept  = tick && !hold && differs && (run_cnt == RUN_LAST);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync_a <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_q <= sync_a;
        end
    end

    // A level must differ on RUN consecutive samples; any agreeing sample restarts the run
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            level   <= 1'b0;
            run_cnt <= CNT_ZERO;
        end else if (tick && !hold) begin
            if (!differs) begin
                run_cnt <= CNT_ZERO;
            end else if (accept) begin
                level   <= sync_q;
                run_cnt <= CNT_ZERO;
            end else begin
                run_cnt <= run_cnt + CNT_ONE;
            end
        end
    end

    chk_run_before_accept: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (level != $past(level)) |-> ($past(run_cnt) == RUN_LAST))
        else $error("level changed before a full run of samples");

    generate
        if (FREE_TICK) begin : g_free
            chk_four_samples_seen: assert property (
                @(posedge sys_clk) disable iff (!nrst)
                (level != $past(level)) && $past(nrst, 4) |->
                    ($past(sync_q, 1) == level) && ($past(sync_q, 2) == level)
                    && ($past(sync_q, 3) == level) && ($past(sync_q, 4) == level))
                else $error("fixed pin accepted a level held under four samples");
        end
    endgenerate

endmodule

/* File: pin_edge_noise_filter.sv */
// Seven-pin edge detector with digital and delay-based noise rejection
`timescale 1ns/1ps
// Functional notes
// - Tunable pin sampled on selected clock; new level needs four equal samples.
// - Levels lasting three samples or fewer are dropped and never make an edge.
// - Three fixed pins use the same four-sample rule on the core clock.
// - Tunable pin edge appears three to four sample periods plus three core clocks after the pin edge.
// - Fixed pin edge appears six to seven core clocks after the pin edge.
// - During an edge-select write, edges on affected pins are not guaranteed.
// - Delay pins reject pulses shorter than about ten microseconds.
// - Delay pin edges may lag the real edge by up to ten microseconds.
// - Each pin has a programmable rising or falling valid edge, mirrored on the edge_select output.
// - Sample clock selection is writable and reset clears it to zero.
// - Deep standby stops detection except on the nmi and two delay pins.
module pin_edge_noise_filter
    import pin_edge_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire pin_set_s                pins,
    input  wire logic [LOW_GROUP_W-1:0]  edge_select_low_wdata,
    input  wire logic                    edge_select_low_we,
    input  wire logic [HIGH_GROUP_W-1:0] edge_select_high_wdata,
    input  wire logic                    edge_select_high_we,
    input  wire logic [SEL_W-1:0]        sample_clock_select_wdata,
    input  wire logic                    sample_clock_select_we,
    input  wire logic                    deep_standby,
    output pin_set_s                     edge_pulse,
    output logic [PIN_COUNT-1:0]         edge_select,
    output logic [SEL_W-1:0]             sample_clock_select
);

    logic [LOW_GROUP_W-1:0]  edge_select_reg_low;
    logic [HIGH_GROUP_W-1:0] edge_select_reg_high;
    logic [PRESCALE_W-1:0]   prescale;
    logic [PIN_COUNT-1:0]    level;
    logic [PIN_COUNT-1:0]    level_q;

    wire logic [PIN_COUNT-1:0] pin_vec = pins;
    wire logic [PIN_COUNT-1:0] sel_vec = {edge_select_reg_high, edge_select_reg_low};

    // Divide ratio 1, 4, 16 or 64; slow settings suit chattering switches
    wire logic [PRESCALE_W-1:0] tick_mask =
        (sample_clock_select == 2'h0) ? 6'h00 :
        (sample_clock_select == 2'h1) ? 6'h03 :
        (sample_clock_select == 2'h2) ? 6'h0F : 6'h3F;
    wire logic sample_tick = ((prescale & tick_mask) == PRESCALE_RESET);

    // Pins that stop in deep standby: tunable and the three fixed pins
    wire logic [PIN_COUNT-1:0] stop_mask = {2'h0, {4{deep_standby}}, 1'b0};

    // A write masks its group for one cycle, so a half-changed polarity never fires
    wire logic [PIN_COUNT-1:0] write_mask =
        {{HIGH_GROUP_W{edge_select_high_we}}, {LOW_GROUP_W{edge_select_low_we}}};

    wire logic [PIN_COUNT-1:0] changed = level ^ level_q;
    wire logic [PIN_COUNT-1:0] polarity_ok = ~(level ^ sel_vec);
    wire logic [PIN_COUNT-1:0] next_edge = changed & polarity_ok & ~stop_mask & ~write_mask;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sample_clock_select <= SAMPLE_SEL_RESET;
            prescale            <= PRESCALE_RESET;
        end else begin
            prescale <= prescale + 6'h01;
            if (sample_clock_select_we) begin
                sample_clock_select <= sample_clock_select_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            edge_select_reg_low  <= EDGE_LOW_RESET;
            edge_select_reg_high <= EDGE_HIGH_RESET;
            edge_select          <= {EDGE_HIGH_RESET, EDGE_LOW_RESET};
        end else begin
            if (edge_select_low_we) begin
                edge_select_reg_low <= edge_select_low_wdata;
            end
            if (edge_select_high_we) begin
                edge_select_reg_high <= edge_select_high_wdata;
            end
            edge_select <= {edge_select_high_we ? edge_select_high_wdata : edge_select_reg_high,
                            edge_select_low_we ? edge_select_low_wdata : edge_select_reg_low};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            level_q    <= {PIN_COUNT{1'b0}};
            edge_pulse <= '0;
        end else begin
            level_q    <= level;
            edge_pulse <= next_edge;
        end
    end

    // The delay pins model the analog filter as a fixed hold time within the bound
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            localparam bit IS_ANALOG = (gi == IDX_NMI) || (gi >= IDX_ANALOG_A);
            localparam bit IS_FIXED  = (gi >= IDX_FIXED_LO) && (gi <= IDX_FIXED_HI);
            level_qualifier #(
                .RUN       (IS_ANALOG ? ANALOG_RUN : DIGITAL_RUN),
                .FREE_TICK (IS_FIXED)
            ) u_qual (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .pin     (pin_vec[gi]),
                .tick    ((gi == IDX_TUNABLE) ? sample_tick : 1'b1),
                .hold    (stop_mask[gi]),
                .level   (level[gi])
            );
        end
    endgenerate

    chk_sel_reset_zero: assert property (
        @(posedge sys_clk) !nrst |=> (sample_clock_select == SAMPLE_SEL_RESET))
        else $error("sample clock select not cleared by reset");

    chk_standby_stops_digital: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        deep_standby |=> (edge_pulse[IDX_FIXED_HI:IDX_TUNABLE] == 4'h0))
        else $error("digital pin edge during deep standby");

    chk_write_masks_group: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        edge_select_low_we |=> (edge_pulse[IDX_FIXED_LO+1:IDX_NMI] == 4'h0))
        else $error("edge reported during edge select write");

    chk_edge_polarity_match: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        edge_pulse.tunable_filter_pin |->
            ($past(level[IDX_TUNABLE]) == $past(sel_vec[IDX_TUNABLE]))
            && ($past(level[IDX_TUNABLE], 2) != $past(level[IDX_TUNABLE])))
        else $error("tunable edge has wrong polarity or no level change");

    chk_edge_single_cycle: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        edge_pulse.fixed_filter_pin_a |=> !edge_pulse.fixed_filter_pin_a)
        else $error("edge pulse longer than one cycle");

    chk_fast_tick_always: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sample_clock_select == SAMPLE_SEL_RESET) |-> sample_tick)
        else $error("undivided sample clock skipped a tick");

    chk_fixed_latency_bound: assert property (
        @(posedge sys_clk) disable iff (!nrst || deep_standby)
        $rose(pins.fixed_filter_pin_b) ##1 pins.fixed_filter_pin_b [*7]
            |-> ##[0:1] level[IDX_FIXED_LO+1])
        else $error("fixed pin edge not detected within bound");

    chk_analog_short_drop: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (level[IDX_ANALOG_A] != $past(level[IDX_ANALOG_A]))
            |-> ($past(pins.analog_delay_pin_a, SYNC_STAGES + 1) == level[IDX_ANALOG_A]))
        else $error("delay pin accepted a level no longer held");

endmodule

/* File: pin_source.sv */
// Behavioural source that drives the seven external pins
`timescale 1ns/1ps
module pin_source
    import pin_edge_pkg::*;
(
    input  wire logic sys_clk,
    output pin_set_s  pins
);
    initial pins = '0;
    // Levels move just after a falling edge, well away from the sampling edge
    task automatic put(input logic [PIN_COUNT-1:0] mask, input logic v);
        @(negedge sys_clk);
        // Clean single-step levels only; clock-locked noise is the board's job
        pins = v ? (pins | mask) : (pins & ~mask);
    endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the pin edge noise filter
`timescale 1ns/1ps
module tb
    import pin_edge_pkg::*;
;
    logic         sys_clk;
    logic         nrst;
    logic [3:0]   lo_d;
    logic         lo_we;
    logic [2:0]   hi_d;
    logic         hi_we;
    logic [1:0]   sel_d;
    logic         sel_we;
    logic         deep_standby;
    pin_set_s     pins;
    pin_set_s     edge_pulse;
    logic [6:0]   edge_select;
    logic [1:0]   sample_clock_select;
    int           cyc = 0;
    int           n_fail = 0;
    int           comparisons = 0;
    logic [6:0]   exp_q[$];
    int           lo_q[$];
    int           hi_q[$];
    logic [15:0]  seed = 16'hDABB;

    pin_source src (.sys_clk(sys_clk), .pins(pins));
    pin_edge_noise_filter dut (.sys_clk(sys_clk), .nrst(nrst), .pins(pins),
        .edge_select_low_wdata(lo_d), .edge_select_low_we(lo_we),
        .edge_select_high_wdata(hi_d), .edge_select_high_we(hi_we),
        .sample_clock_select_wdata(sel_d), .sample_clock_select_we(sel_we),
        .deep_standby(deep_standby), .edge_pulse(edge_pulse),
        .edge_select(edge_select), .sample_clock_select(sample_clock_select));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Timeout well above the few thousand cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc > 10000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // Any pulse must match the oldest note, inside its time window
    always @(negedge sys_clk) begin : watch
        int lo;
        int hi;
        if (nrst === 1'b1 && edge_pulse !== '0) begin
            if (exp_q.size() == 0) begin
                check(edge_pulse, 0);
            end else begin
                lo = lo_q.pop_front();
                hi = hi_q.pop_front();
                check(edge_pulse, exp_q.pop_front());
                check(cyc >= lo && cyc <= hi, 1);
            end
        end
    end

    task automatic wr(input int which, input logic [3:0] d);
        @(negedge sys_clk);
        lo_d = d;
        hi_d = d[2:0];
        sel_d = d[1:0];
        lo_we = (which == 0);
        hi_we = (which == 1);
        sel_we = (which == 2);
        @(negedge sys_clk);
        lo_we = 1'b0;
        hi_we = 1'b0;
        sel_we = 1'b0;
        @(negedge sys_clk);
    endtask

    // High pulse of w cycles on the masked pins; er/ef note an expected edge
    task automatic pulse(input logic [6:0] m, input int w, input logic er, input logic ef,
                         input int hi_off, input int gap);
        src.put(m, 1'b1);
        if (er) begin
            exp_q.push_back(m);
            lo_q.push_back(cyc + 6);
            hi_q.push_back(cyc + hi_off);
        end
        repeat (w - 1) @(negedge sys_clk);
        src.put(m, 1'b0);
        if (ef) begin
            exp_q.push_back(m);
            lo_q.push_back(cyc + 6);
            hi_q.push_back(cyc + hi_off);
        end
        repeat (gap) @(negedge sys_clk);
    endtask

    initial begin
        nrst = 1'b0;
        {lo_d, lo_we, hi_d, hi_we, sel_d, sel_we, deep_standby} = '0;
        repeat (3) @(negedge sys_clk);
        check(edge_select, 0);
        check(sample_clock_select, 0);
        nrst = 1'b1;
        for (int s = 1; s >= 0; s--) begin
            wr(0, {4{s[0]}});
            wr(1, {4{s[0]}});
            check(edge_select, {7{s[0]}});
            for (int i = 1; i <= 4; i++) begin
                pulse(7'h01 << i, 12, s[0], !s[0], 8, 12);
            end
        end
        $display("test polarity done");
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            pulse(7'h04 << (seed % 3), 1 + seed[4:0] % 3, 1'b0, 1'b0, 0, 8);
        end
        $display("test noise done");
        for (int d = 0; d < 4; d++) begin
            wr(2, d[3:0]);
            check(sample_clock_select, d);
        end
        wr(2, 4'h1);
        wr(0, 4'hF);
        pulse(7'h02, 8, 1'b0, 1'b0, 0, 40);
        pulse(7'h02, 40, 1'b1, 1'b0, 26, 40);
        wr(2, 4'h2);
        pulse(7'h02, 40, 1'b0, 1'b0, 0, 100);
        pulse(7'h02, 100, 1'b1, 1'b0, 68, 100);
        $display("test tunable done");
        // Rewrite the low group in the very cycle the fixed pin edge qualifies
        src.put(7'h04, 1'b1);
        repeat (5) @(negedge sys_clk);
        wr(0, 4'hF);
        src.put(7'h04, 1'b0);
        repeat (20) @(negedge sys_clk);
        $display("test write mask done");
        wr(1, 4'h7);
        pulse(7'h61, 100, 1'b0, 1'b0, 0, 600);
        pulse(7'h61, 600, 1'b1, 1'b0, 502, 600);
        $display("test analog done");
        deep_standby = 1'b1;
        pulse(7'h1E, 12, 1'b0, 1'b0, 0, 12);
        pulse(7'h61, 600, 1'b1, 1'b0, 502, 600);
        deep_standby = 1'b0;
        $display("test standby done");
        check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule
